// ==== logic/dacbi_host.sv ====
// host controller writing a word into the double-buffered converter
// Functional notes
// - data may appear together with select and byte strobes, zero setup
// - low strobe held high at least 100 ns, falling edge freezes
// - high strobe loads eight upper bits the same way
// - load strobe held high at least 100 ns
// - wait 5 us full-scale or 1 us one-lsb before output valid
// - eight-bit bus: address bits 2,1,0 drive load, high, low strobes
// - sixteen-bit bus: byte strobes tied to bit 0, load to bit 1
// - bytes may load in either order before load strobe
// - select held low at least 100 ns per access
module dacbi_host
    import dacbi_pkg::*;
(
    input  wire logic        clk_sys_in,        // 20 mhz clock
    input  wire logic        reset_in,          // async reset, active high
    input  wire logic        clk_en_in,         // freezes all state while low
    input  wire logic        wide_bus_in,       // 1: 16-bit wiring, 0: 8-bit wiring
    input  wire logic        req_valid_in,      // write request
    input  wire logic [15:0] req_word_in,       // word to convert
    input  wire logic        req_high_first_in, // 8-bit: upper byte first
    input  wire logic        req_no_load_in,    // fill first buffer only
    output logic             req_ready_out,     // high while idle, even with clk_en_in low; a request is taken only while clk_en_in is high
    output logic             out_valid_out,     // output settled after last load
    output logic             select_n_out,      // device select, active low
    output logic             low_byte_strobe_out,       // lower register strobe
    output logic             high_byte_strobe_out,      // upper register strobe
    output logic             converter_load_strobe_out, // second buffer strobe
    output logic [15:0]      data_out           // data pins
);
    dacbi_state_e state;
    dacbi_pins_s  pins;
    logic [7:0]   count;
    logic         second;      // second byte phase in 8-bit mode
    logic         wide;
    logic         high_first;
    logic         no_load;
    logic [15:0]  word;
    logic [15:0]  last_word;   // what the second buffer now holds
    logic [7:0]   settle_cnt;

    // settling count: small steps settle faster
    function automatic logic [7:0] settle_for(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] d;
        d = (a > b) ? (a - b) : (b - a);
        return (d <= 16'h0001) ? CNT_LSB : CNT_FULL;
    endfunction : settle_for

    assign req_ready_out             = (state == ST_IDLE);
    assign select_n_out              = pins.select_n;
    assign low_byte_strobe_out       = pins.low_byte_strobe;
    assign high_byte_strobe_out      = pins.high_byte_strobe;
    assign converter_load_strobe_out = pins.converter_load_strobe;
    assign data_out                  = pins.data;

    // sequencer: select and data first, then each strobe held its least width
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state      <= ST_IDLE;
            count      <= 8'h00;
            second     <= 1'b0;
            wide       <= 1'b0;
            high_first <= 1'b0;
            no_load    <= 1'b0;
            word       <= WORD_RESET;
            pins       <= '{select_n: 1'b1, low_byte_strobe: 1'b0, high_byte_strobe: 1'b0,
                            converter_load_strobe: 1'b0, data: WORD_RESET};
        end else if (clk_en_in) begin
            unique case (state)
                ST_IDLE: begin
                    if (req_valid_in) begin
                        word          <= req_word_in;
                        wide          <= wide_bus_in;
                        high_first    <= req_high_first_in;
                        no_load       <= req_no_load_in;
                        second        <= 1'b0;
                        pins.select_n <= 1'b0;
                        pins.data     <= wide_bus_in ? req_word_in :
                                         (req_high_first_in ? {2{req_word_in[15:8]}}
                                                            : {2{req_word_in[7:0]}});
                        state         <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // one strobe at a time on a narrow bus avoids the invalid codes
                    if (wide) begin
                        pins.low_byte_strobe  <= 1'b1;
                        pins.high_byte_strobe <= 1'b1;
                    end else if (high_first ^ second) begin
                        pins.high_byte_strobe <= 1'b1;
                    end else begin
                        pins.low_byte_strobe  <= 1'b1;
                    end
                    count <= CNT_STROBE;
                    state <= ST_LOW;
                end
                ST_LOW: begin
                    if (count > 8'h01) begin
                        count <= count - 8'h01;
                    end else begin
                        pins.low_byte_strobe  <= 1'b0; // falling edge freezes
                        pins.high_byte_strobe <= 1'b0;
                        state <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    // second byte in either order before the load strobe
                    if (!wide && !second) begin
                        second    <= 1'b1;
                        pins.data <= high_first ? {2{word[7:0]}} : {2{word[15:8]}};
                        state     <= ST_SETUP;
                    end else begin
                        pins.select_n <= 1'b1;
                        state         <= no_load ? ST_IDLE : ST_GAP;
                    end
                end
                ST_GAP: begin
                    // load strobe needs no select on the device side
                    pins.converter_load_strobe <= 1'b1;
                    count <= CNT_STROBE;
                    state <= ST_LOAD;
                end
                ST_LOAD: begin
                    if (count > 8'h01) begin
                        count <= count - 8'h01;
                    end else begin
                        pins.converter_load_strobe <= 1'b0;
                        state <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (settle_cnt == 8'h00) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // settling timer and model of the held second-buffer word
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            settle_cnt    <= 8'h00;
            last_word     <= MIDSCALE;
            out_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            if (state == ST_GAP) begin
                settle_cnt    <= settle_for(word, last_word);
                last_word     <= word;
                out_valid_out <= 1'b0;
            end else if (settle_cnt != 8'h00) begin
                settle_cnt <= settle_cnt - 8'h01;
            end else if (state == ST_SETTLE) begin
                out_valid_out <= 1'b1;
            end
        end
    end

    // byte strobes only inside a select window
    property p_strobe_sel;
        @(posedge clk_sys_in) disable iff (reset_in)
        (low_byte_strobe_out || high_byte_strobe_out) |-> !select_n_out;
    endproperty
    a_strobe_sel: assert property (p_strobe_sel) else $error("byte strobe without select");

    property p_low_width;
        @(posedge clk_sys_in) disable iff (reset_in)
        $rose(low_byte_strobe_out) |-> low_byte_strobe_out[*2];
    endproperty
    a_low_width: assert property (p_low_width) else $error("low strobe too short");

    property p_high_width;
        @(posedge clk_sys_in) disable iff (reset_in)
        $rose(high_byte_strobe_out) |-> high_byte_strobe_out[*2];
    endproperty
    a_high_width: assert property (p_high_width) else $error("high strobe too short");

    property p_load_width;
        @(posedge clk_sys_in) disable iff (reset_in)
        $rose(converter_load_strobe_out) |-> converter_load_strobe_out[*2];
    endproperty
    a_load_width: assert property (p_load_width) else $error("load strobe too short");

    property p_no_invalid;
        @(posedge clk_sys_in) disable iff (reset_in)
        !wide |-> !(low_byte_strobe_out && (high_byte_strobe_out || converter_load_strobe_out));
    endproperty
    a_no_invalid: assert property (p_no_invalid) else $error("invalid strobe code");

    property p_select_width;
        @(posedge clk_sys_in) disable iff (reset_in)
        $fell(select_n_out) |-> !select_n_out[*3];
    endproperty
    a_select_width: assert property (p_select_width) else $error("select too short");

    property p_data_stable;
        @(posedge clk_sys_in) disable iff (reset_in || !clk_en_in)
        (low_byte_strobe_out || high_byte_strobe_out) |=> $stable(data_out);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved under strobe");

    property p_settle;
        @(posedge clk_sys_in) disable iff (reset_in)
        $rose(converter_load_strobe_out) |-> !out_valid_out[*8];
    endproperty
    a_settle: assert property (p_settle) else $error("output valid too early");

    c_narrow: cover property (@(posedge clk_sys_in) disable iff (reset_in)
        !wide && $fell(converter_load_strobe_out));
    c_wide: cover property (@(posedge clk_sys_in) disable iff (reset_in)
        wide && $fell(converter_load_strobe_out));
    c_valid: cover property (@(posedge clk_sys_in) disable iff (reset_in) $rose(out_valid_out));
endmodule : dacbi_host

// ==== pkg/dacbi_pkg.sv ====
// package for the double-buffered converter bus host controller
package dacbi_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 50;    // 20 mhz system clock
    localparam int unsigned STROBE_MIN_NS   = 100;   // least strobe and select width
    localparam int unsigned SETUP_MIN_NS    = 0;     // data setup before strobes
    localparam int unsigned SETTLE_FULL_NS  = 5000;  // full-scale settling
    localparam int unsigned SETTLE_LSB_NS   = 1000;  // midscale one-lsb settling
    // least times round up to whole cycles, never below one
    localparam int unsigned STROBE_CYC =
        ((STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int unsigned SETUP_CYC       = 1;     // one cycle of data before strobe
    localparam int unsigned SETTLE_FULL_CYC =
        (SETTLE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_LSB_CYC  =
        (SETTLE_LSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  CNT_STROBE      = 8'(STROBE_CYC);
    localparam logic [7:0]  CNT_FULL        = 8'(SETTLE_FULL_CYC);
    localparam logic [7:0]  CNT_LSB         = 8'(SETTLE_LSB_CYC);
    localparam logic [15:0] WORD_RESET      = 16'h0000;
    localparam logic [15:0] MIDSCALE        = 16'h8000;

    // pins driven toward the converter
    typedef struct packed {
        logic        select_n;
        logic        low_byte_strobe;
        logic        high_byte_strobe;
        logic        converter_load_strobe;
        logic [15:0] data;
    } dacbi_pins_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_LOW   = 3'b010,
        ST_HIGH  = 3'b011,
        ST_GAP   = 3'b100,
        ST_LOAD  = 3'b101,
        ST_SETTLE= 3'b110
    } dacbi_state_e;
endpackage : dacbi_pkg

// ==== verif/dacbi_conv_model.sv ====
// behavioural model of the double-buffered converter inputs
module dacbi_conv_model
    import dacbi_pkg::*;
(
    input  wire logic        clk_in,                   // sample clock for width checks
    input  wire logic        wide_bus_in,              // 1: byte strobes tied together
    input  wire logic        select_n_in,              // device select, active low
    input  wire logic        low_byte_strobe_in,       // lower register strobe
    input  wire logic        high_byte_strobe_in,      // upper register strobe
    input  wire logic        converter_load_strobe_in, // second buffer strobe
    input  wire logic [15:0] data_in,                  // data pins
    output logic      [15:0] first_word_out,           // first buffer contents
    output logic      [15:0] dac_word_out,             // second buffer contents
    output logic      [31:0] fault_count_out           // host timing or code faults
);
    timeunit 1ns;
    timeprecision 1ps;
    int  width [4];
    logic [3:0] lv;
    logic [7:0] low_reg;   // lower register of the first buffer
    logic [7:0] high_reg;  // upper register of the first buffer

    // byte latches are transparent while selected and strobed, frozen on fall
    always_latch begin
        if (!select_n_in && low_byte_strobe_in) begin
            low_reg = data_in[7:0];
        end
    end
    always_latch begin
        if (!select_n_in && high_byte_strobe_in) begin
            high_reg = data_in[15:8];
        end
    end
    // one driver per byte keeps the two latches independent
    assign first_word_out = {high_reg, low_reg};
    // load latch ignores select; chained latches give the bus-through cases
    always_latch begin
        if (converter_load_strobe_in) begin
            dac_word_out = first_word_out;
        end
    end

    // counts in whole cycles, so a short pulse between edges can slip past
    assign lv = {!select_n_in, low_byte_strobe_in, high_byte_strobe_in, converter_load_strobe_in};
    initial begin
        fault_count_out = 32'h0;
        for (int k = 0; k < 4; k++) width[k] = 0;
    end
    always @(negedge clk_in) begin
        for (int k = 0; k < 4; k++) begin
            if (lv[k]) begin
                width[k]++;
            end else begin
                if (width[k] != 0 && width[k] < int'(STROBE_CYC)) fault_count_out++;
                width[k] = 0;
            end
        end
        if (!wide_bus_in && lv[2] && (lv[1] || lv[0])) fault_count_out++;
        if (wide_bus_in && (lv[2] != lv[1])) fault_count_out++;
    end
endmodule : dacbi_conv_model

// ==== verif/tb_top.sv ====
// self-checking bench for the converter bus host controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dacbi_pkg::*;
    logic clk_sys_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1, wide_bus_in = 1'b0;
    logic req_valid_in = 1'b0, req_high_first_in = 1'b0, req_no_load_in = 1'b0;
    logic [15:0] req_word_in = 16'h0000, data_out, first_word, dac_word;
    logic req_ready_out, out_valid_out, select_n_out, low_s, high_s, load_s;
    logic [31:0] faults;
    int n_fail = 0, n_checks = 0, settle = 0;

    always #25 clk_sys_in = ~clk_sys_in;

    dacbi_host DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
        .wide_bus_in(wide_bus_in), .req_valid_in(req_valid_in), .req_word_in(req_word_in),
        .req_high_first_in(req_high_first_in), .req_no_load_in(req_no_load_in),
        .req_ready_out(req_ready_out), .out_valid_out(out_valid_out),
        .select_n_out(select_n_out), .low_byte_strobe_out(low_s),
        .high_byte_strobe_out(high_s), .converter_load_strobe_out(load_s), .data_out(data_out));

    dacbi_conv_model model (.clk_in(clk_sys_in), .wide_bus_in(wide_bus_in),
        .select_n_in(select_n_out), .low_byte_strobe_in(low_s), .high_byte_strobe_in(high_s),
        .converter_load_strobe_in(load_s), .data_in(data_out), .first_word_out(first_word),
        .dac_word_out(dac_word), .fault_count_out(faults));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one request; settle holds cycles from load strobe rise to ready return
    task automatic wr(input logic [15:0] word, input logic wide, input logic hf, input logic nl);
        int i;
        int ld;
        ld = -1;
        @(posedge clk_sys_in);
        req_word_in       <= word;
        wide_bus_in       <= wide;
        req_high_first_in <= hf;
        req_no_load_in    <= nl;
        req_valid_in      <= 1'b1;
        @(posedge clk_sys_in);
        req_valid_in <= 1'b0;
        for (i = 0; i < 400; i++) begin
            @(posedge clk_sys_in);
            if (load_s === 1'b1 && ld < 0) ld = i;
            if (req_ready_out === 1'b1) break;
        end
        if (i >= 400) n_fail++;
        settle = i - ld;
    endtask : wr

    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // a hang past the expected run counts as a failure
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge clk_sys_in);
        chk({select_n_out, low_s, high_s, load_s, req_ready_out, out_valid_out}, 32'h22);
        reset_in <= 1'b0;
        wr(16'h1234, 1'b0, 1'b0, 1'b0);
        chk(dac_word, 32'h1234);
        chk(32'(settle >= int'(SETTLE_FULL_CYC)), 32'h1);
        chk(out_valid_out, 32'h1);
        wr(16'h1235, 1'b0, 1'b1, 1'b0);
        chk(dac_word, 32'h1235);
        chk(32'(settle >= int'(SETTLE_LSB_CYC) && settle < int'(SETTLE_FULL_CYC)), 32'h1);
        wr(16'habcd, 1'b0, 1'b0, 1'b1);
        chk(first_word, 32'habcd);
        chk(dac_word, 32'h1235);
        wr(16'h5a5a, 1'b1, 1'b0, 1'b0);
        chk(dac_word, 32'h5a5a);
        wr(16'ha5a5, 1'b1, 1'b0, 1'b0);
        chk(dac_word, 32'ha5a5);
        // a frozen controller must neither take a request nor touch its pins
        @(posedge clk_sys_in);
        clk_en_in    <= 1'b0;
        req_valid_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        chk({select_n_out, req_ready_out}, 32'h3);
        clk_en_in    <= 1'b1;
        req_valid_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        chk({select_n_out, req_ready_out}, 32'h3);
        chk(faults, 32'h0);
        end_sim();
    end
endmodule : tb_top
